/* core/sram_port_pkg.sv */
// How it works
// [RL1] sample synchronous inputs only on rising clock
// [RL2] advance low during burst increments burst count
// [RL3] processor strobe ignored while primary select high
// [RL4] selected: primary low, high select high, low select low
// [RL5] missing low select behaves as always asserted
// [RL6] output enable low drives pins, high releases
// [RL7] first read clock after deselect keeps pins undriven
// [RL8] processor strobe loads address and burst count
// [RL9] controller strobe loads address and burst count
// [RL10] both strobes low: processor strobe wins
// [RL11] sleep high holds array, contents kept
// [RL12] sleep normally low; open treated as low
// [RL13] input data captured into write register
// [RL14] read data appears one edge after address
// [RL15] strap low linear, high interleaved order
// [RL16] global write writes every byte lane
// [RL17] two bit wrapping burst counter
package sram_port_pkg;
   localparam int ADDR_W  = 10;          // address width (array size)
   localparam int LANES   = 4;           // byte lanes
   localparam int DATA_W  = LANES * 8;   // data width
   localparam int PAR_W   = LANES;       // one parity bit per lane
   localparam int BURST_W = 2;           // burst counter width
   localparam int WORD_W  = DATA_W + PAR_W;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0; // counter reset value

   // synchronous control group sampled at each rising edge
   typedef struct packed {
      logic              primary_chip_select_n;
      logic              depth_select_high;
      logic              depth_select_low_n;
      logic              processor_addr_strobe_n;
      logic              controller_addr_strobe_n;
      logic              burst_advance_n;
      logic              global_write_n;
      logic              byte_write_gate_n;
      logic [LANES-1:0]  byte_lane_select_n;
   } ctrl_t;

   // bidirectional data pin bundle (data and parity)
   typedef struct packed {
      logic [PAR_W-1:0]  parity;
      logic [DATA_W-1:0] data;
   } word_t;

   // access kind held in the pipeline
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } acc_t;
endpackage

/* core/sram_port_mem.sv */
`timescale 1ns/1ps
// word store with per lane write enables and registered read data
module sram_port_mem #(
   parameter int AW    = 10,
   parameter int LANES = 4
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_hold,   // sleep: freeze array and read port
   input  wire logic [AW-1:0]         i_raddr,
   output logic      [LANES*9-1:0]    o_rdata,  // lane k: data byte, then parity bit
   input  wire logic [AW-1:0]         i_waddr,
   input  wire logic [LANES-1:0]      i_wen,
   input  wire logic [LANES*9-1:0]    i_wdata
);
   logic [LANES*9-1:0] mem [2**AW]; // array, no reset: contents survive sleep

   // per lane write, held off while asleep so contents stay intact;
   // one process for all lanes, since the array may have only one writer
   always_ff @(posedge i_clk)
   begin
      if (!i_hold)
      begin
         for (int k = 0; k < LANES; k++)
         begin
            if (i_wen[k])
            begin
               mem[i_waddr][k*9 +: 9] <= i_wdata[k*9 +: 9];
            end
         end
      end
   end

   // registered read output
   always_ff @(posedge i_clk)
   begin
      if (!i_hold)
      begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule // sram_port_mem

/* core/sram_port.sv */
`timescale 1ns/1ps
module pipelined_burst_sram_port
   import sram_port_pkg::*;
#(
   parameter bit HAS_LOW_SELECT = 1'b1   // 0: package without the low depth select
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_arst_n,
   input  wire sram_port_pkg::ctrl_t       i_ctrl,       // synchronous controls
   input  wire logic [sram_port_pkg::ADDR_W-1:0] i_addr,  // address pins
   input  wire logic                       i_output_enable_n, // asynchronous
   input  wire logic                       i_sleep_request,   // asynchronous, active high
   input  wire logic                       i_burst_mode,      // strap: 0 linear, 1 interleaved
   input  wire sram_port_pkg::word_t       i_dq,         // pin level in
   output sram_port_pkg::word_t            o_dq,         // pin level out
   output logic                            o_dq_oe_n,    // low while driving pins
   output logic                            o_sleeping    // low activity state
);
   import sram_port_pkg::*;

   logic                     rst_meta_reg;  // reset release synchroniser
   logic                     rst_n_reg;
   ctrl_t                    ctrl_reg;      // registered controls
   logic [ADDR_W-1:0]        addr_reg;      // captured base address
   logic [BURST_W-1:0]       cnt_reg;       // burst counter
   logic                     mode_reg;      // strap copy
   acc_t                     acc_reg;       // pending access kind
   logic                     first_read_reg; // first read after deselect
   word_t                    wdata_reg;     // captured write data
   logic [LANES-1:0]         wen;
   logic [LANES*9-1:0]       rword;
   logic [LANES*9-1:0]       wword;
   logic [ADDR_W-1:0]        cur_addr;
   logic                     selected;
   logic                     psel;
   logic                     csel;
   logic                     start;
   logic                     sleeping;

   // burst offset for step n from base in the chosen order
   function automatic logic [BURST_W-1:0] burst_ofs(input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] n,
                                                    input logic               il);
      burst_ofs = il ? (base ^ n) : BURST_W'(base + n);
   endfunction

   // reset release through two flops
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // sleep is asynchronous; its pull-down lives outside the core
   assign sleeping   = i_sleep_request; // RL11 RL12
   assign o_sleeping = sleeping;

   // select decode on live pins, sampled at the edge below
   assign selected = !i_ctrl.primary_chip_select_n && i_ctrl.depth_select_high
                     && (!HAS_LOW_SELECT || !i_ctrl.depth_select_low_n); // RL4 RL5
   assign psel  = !i_ctrl.processor_addr_strobe_n && !i_ctrl.primary_chip_select_n; // RL3 RL10
   assign csel  = !psel && !i_ctrl.controller_addr_strobe_n; // RL9 RL10
   assign start = psel || csel;

   // strap caught after reset release
   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         mode_reg <= 1'b1;
      else
         mode_reg <= i_burst_mode; // RL15
   end

   // input capture, rising edge only
   always_ff @(posedge i_clk)
   begin
      ctrl_reg  <= i_ctrl;   // RL1
      wdata_reg <= i_dq;     // RL13
   end

   // address register and burst counter
   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         addr_reg <= '0;
         cnt_reg  <= BURST_RST;
      end
      else if (!sleeping)
      begin
         if (start && selected)
         begin
            addr_reg <= i_addr;            // RL8 RL9
            cnt_reg  <= BURST_RST;         // RL8 offset zero from the loaded low bits
         end
         else if (!i_ctrl.burst_advance_n && acc_reg != ST_IDLE)
         begin
            cnt_reg <= BURST_W'(cnt_reg + 1'b1); // RL2 RL17 wraps
         end
      end
   end

   // access kind: write when global write, or byte gate with a lane, is asserted at the edge without the processor strobe
   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         acc_reg        <= ST_IDLE;
         first_read_reg <= 1'b0;
      end
      else if (!sleeping)
      begin
         // conditions overlap, so the order of the tests decides
         if (start && !selected)
         begin
            acc_reg        <= ST_IDLE; // deselect
            first_read_reg <= 1'b0;
         end
         else if (start || acc_reg != ST_IDLE)
         begin
            // processor strobe always starts a read; writes follow later
            if (!psel && (!i_ctrl.global_write_n || (!i_ctrl.byte_write_gate_n
                && !(&i_ctrl.byte_lane_select_n))))
               acc_reg <= ST_WRITE;
            else
               acc_reg <= ST_READ;
            first_read_reg <= start && acc_reg == ST_IDLE; // RL7
         end
         else
         begin
            // parked with no strobe: stay idle
            acc_reg        <= ST_IDLE;
            first_read_reg <= 1'b0;
         end
      end
   end

   // current word address: base with low bits walked
   assign cur_addr = {addr_reg[ADDR_W-1:BURST_W],
                      burst_ofs(addr_reg[BURST_W-1:0], cnt_reg, mode_reg)};

   // lane write enables from the registered controls
   always_comb
   begin
      wen = '0;
      if (acc_reg == ST_WRITE)
      begin
         if (!ctrl_reg.global_write_n)
            wen = '1;                                      // RL16
         else if (!ctrl_reg.byte_write_gate_n)
            wen = ~ctrl_reg.byte_lane_select_n;
      end
   end

   // pack lanes: data byte then parity bit
   genvar g;
   for (g = 0; g < LANES; g++)
   begin : g_pack
      assign wword[g*9 +: 9] = {wdata_reg.parity[g], wdata_reg.data[g*8 +: 8]};
      assign o_dq.data[g*8 +: 8] = rword[g*9 +: 8];   // RL14
      assign o_dq.parity[g]      = rword[g*9 + 8];
   end

   sram_port_mem #(
      .AW    (ADDR_W),
      .LANES (LANES)
   ) u_mem (
      .i_clk   (i_clk),
      .i_hold  (sleeping),
      .i_raddr (cur_addr),
      .o_rdata (rword),
      .i_waddr (cur_addr),
      .i_wen   (wen),
      .i_wdata (wword)
   );

   // direction: asynchronous enable, masked on first read clock
   assign o_dq_oe_n = i_output_enable_n || first_read_reg
                      || acc_reg != ST_READ;           // RL6 RL7

   // assertions
   property p_oe_follows;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (i_output_enable_n) |-> o_dq_oe_n;
   endproperty
   a_oe_follows: assert property (p_oe_follows) else $error("driving with oe high"); // RL6

   property p_first_mask;
      @(posedge i_clk) disable iff (!rst_n_reg)
      first_read_reg |-> o_dq_oe_n;
   endproperty
   a_first_mask: assert property (p_first_mask) else $error("drove on first read"); // RL7

   property p_adv;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (!sleeping && !start && !i_ctrl.burst_advance_n && acc_reg != ST_IDLE)
      |=> cnt_reg == BURST_W'($past(cnt_reg) + 1'b1);
   endproperty
   a_adv: assert property (p_adv) else $error("burst counter did not advance"); // RL2

   property p_load;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (!sleeping && start && selected) |=> addr_reg == $past(i_addr) && cnt_reg == BURST_RST;
   endproperty
   a_load: assert property (p_load) else $error("address not loaded"); // RL8

   property p_ignore;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (i_ctrl.primary_chip_select_n && i_ctrl.controller_addr_strobe_n && !sleeping)
      |=> addr_reg == $past(addr_reg);
   endproperty
   a_ignore: assert property (p_ignore) else $error("strobe not ignored"); // RL3

   property p_gw;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (acc_reg == ST_WRITE && !ctrl_reg.global_write_n) |-> &wen;
   endproperty
   a_gw: assert property (p_gw) else $error("global write missed a lane"); // RL16

   property p_sleep_hold;
      @(posedge i_clk) disable iff (!rst_n_reg)
      sleeping |=> cnt_reg == $past(cnt_reg) && acc_reg == $past(acc_reg);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep"); // RL11

   property p_desel;
      @(posedge i_clk) disable iff (!rst_n_reg)
      (!sleeping && start && !selected) |=> acc_reg == ST_IDLE;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect not taken"); // RL4
endmodule // pipelined_burst_sram_port

/* sim/ctl_pins.sv */
`timescale 1ns/1ps
// controller side of the data wire: resolves device drive and write drive
module ctl_pins
   import sram_port_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire sram_port_pkg::word_t i_dev_q,    // device output level
   input  wire logic                 i_dev_oe_n, // low while device drives
   input  wire logic                 i_drive,    // controller drives write data
   input  wire sram_port_pkg::word_t i_wdata,    // write data from controller
   output sram_port_pkg::word_t      o_pin       // resolved wire level
);
   word_t last_reg; // last wire value

   // a released wire shows the inverse of the last value,
   // so a stale capture can never pass for a good one
   always_comb
   begin
      if (!i_dev_oe_n)
         o_pin = i_dev_q;
      else if (i_drive)
         o_pin = i_wdata;
      else
         o_pin = ~last_reg;
   end

   // remember the wire for the released case
   always_ff @(posedge i_clk)
      last_reg <= o_pin;
endmodule // ctl_pins

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
   import sram_port_pkg::*;
   localparam ctrl_t IDLE = 12'hdff;     // deselected, strobes and writes high
   logic              i_clk;
   logic              arst_n;
   logic              oe_en_n;           // output enable pin level
   logic              slp;               // sleep request
   logic              mode;              // burst order strap
   logic              drv;               // controller drives the wire
   logic              desel;             // port parked by a deselect
   logic              dq_oe_n;
   logic              sleeping;
   ctrl_t             ctrl;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] blk;
   logic [1:0]        b;
   word_t             wdata;
   word_t             pin;
   word_t             dq_out;
   logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1]; // reference store
   int                fail_count;
   int                n_compared;

   pipelined_burst_sram_port pipelined_burst_sram_port_inst (
      .i_clk(i_clk), .i_arst_n(arst_n), .i_ctrl(ctrl), .i_addr(addr),
      .i_output_enable_n(oe_en_n), .i_sleep_request(slp), .i_burst_mode(mode),
      .i_dq(pin), .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .o_sleeping(sleeping));

   ctl_pins ctl_pins_inst (
      .i_clk(i_clk), .i_dev_q(dq_out), .i_dev_oe_n(dq_oe_n),
      .i_drive(drv), .i_wdata(wdata), .o_pin(pin));

   // free running clock, 4 ns
   initial
   begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end

   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task cmp_w(input word_t g, input word_t e);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value at %0t: data %h expected %h", $time, g, e);
      end
   endtask

   task cmp_b(input logic g, input logic e);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value at %0t: flag %b expected %b", $time, g, e);
      end
   endtask

   // single global write through the controller strobe; data held two edges
   task wr(input logic [ADDR_W-1:0] a, input word_t w, input logic sel);
      ctrl_t c;
      c = IDLE;
      c.primary_chip_select_n = 1'h0;
      c.controller_addr_strobe_n = 1'h0;
      c.global_write_n = 1'h0;
      c.depth_select_high = sel;
      @(posedge i_clk);
      ctrl <= c;
      addr <= a;
      wdata <= w;
      drv <= 1'h1;
      oe_en_n <= 1'h1;
      @(posedge i_clk);
      ctrl <= IDLE;
      @(posedge i_clk);
      drv <= 1'h0;
      if (sel && !slp)
         mem[a] = w;
      if (!slp)
         desel = !sel; // a strobe while deselected parks the port
   endtask

   // processor strobe read, then four advance edges over the whole burst
   task rd(input logic [ADDR_W-1:0] a, input logic en_n, input logic both);
      ctrl_t             c;
      logic [ADDR_W-1:0] x;
      c = IDLE;
      c.primary_chip_select_n = 1'h0;
      c.processor_addr_strobe_n = 1'h0;
      c.controller_addr_strobe_n = !both;
      c.global_write_n = !both;
      @(posedge i_clk);
      ctrl <= c;
      addr <= a;
      oe_en_n <= en_n;
      c = IDLE;
      c.burst_advance_n = 1'h0;
      @(posedge i_clk);
      ctrl <= c;
      #1;
      cmp_b(dq_oe_n, en_n | desel);
      desel = 1'h0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clk);
         if (i == 3)
            ctrl <= IDLE;
         #1;
         x = {a[ADDR_W-1:2], mode ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
         cmp_w(dq_out, mem[x]);
         cmp_b(dq_oe_n, en_n);
      end
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      test_done;
   end

   // main sequence
   initial
   begin
      arst_n = 1'h0;
      ctrl = IDLE;
      addr = '0;
      oe_en_n = 1'h1;
      slp = 1'h0;
      mode = 1'h0;
      drv = 1'h0;
      desel = 1'h1;
      wdata = '0;
      fail_count = 0;
      n_compared = 0;
      void'($urandom(32'h21f9));
      repeat (4) @(posedge i_clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge i_clk);
      for (int m = 0; m < 4; m++)
      begin
         @(posedge i_clk);
         mode <= m[0];
         blk = ADDR_W'($urandom);
         for (int k = 0; k < 4; k++)
            wr({blk[ADDR_W-1:2], 2'(k)}, WORD_W'({$urandom, $urandom}), 1'h1);
         b = 2'($urandom);
         rd({blk[ADDR_W-1:2], b}, m[1], 1'h0);
         wr({blk[ADDR_W-1:2], b}, WORD_W'({$urandom, $urandom}), 1'h0);
         rd({blk[ADDR_W-1:2], b}, 1'h0, 1'h1);
         rd({blk[ADDR_W-1:2], ~b}, 1'h0, 1'h0);
         // processor strobe with primary select high must leave the read running
         @(posedge i_clk);
         ctrl <= ctrl_t'(12'hcff);
         addr <= ADDR_W'($urandom);
         @(posedge i_clk);
         ctrl <= IDLE;
         #1;
         cmp_b(dq_oe_n, 1'h0);
      end
      @(posedge i_clk);
      slp <= 1'h1;
      #1;
      cmp_b(sleeping, 1'h1);
      wr(blk, WORD_W'({$urandom, $urandom}), 1'h1);
      @(posedge i_clk);
      slp <= 1'h0;
      #1;
      cmp_b(sleeping, 1'h0);
      repeat (2) @(posedge i_clk);
      rd(blk, 1'h0, 1'h0);
      test_done;
   end
endmodule // tb
